// ===== core/eia_pkg.sv
// Constants, register map and state encoding for the interrupt recognition block.
// Assumes a single 100 MHz clock and word-aligned register offsets.
package eia_pkg;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses, one word each).
   // -----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_SRCMASK = 8'h04;
   localparam logic [7:0] REG_AVR = 8'h08;
   localparam logic [7:0] REG_VECTOR = 8'h0C;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_IMASK = 8'h14;
   localparam logic [7:0] REG_STATE = 8'h18;

   // -----------------------------------------------------------------
   // Field layouts and reset values.
   // -----------------------------------------------------------------
   localparam int NUM_LVL = 7;
   localparam int LVL_W = 3;
   localparam int EV_W = 3;
   localparam int EV_ACK = 0;
   localparam int EV_AUTOVECTOR_SELECT = 1;
   localparam int EV_NMI = 2;
   localparam int AVR_BLK_BIT = 0;
   localparam logic [2:0] CORE_MASK_RST = 3'h7;
   localparam logic [6:0] SRCMASK_RST = 7'h00;
   localparam logic [6:0] AVR_AUTOVECTOR_SELECT_RST = 7'h00;
   localparam logic AVR_BLK_RST = 1'b1;
   localparam logic [2:0] NMI_LVL = 3'h7;
   localparam logic [2:0] LVL_NONE = 3'h0;

   // -----------------------------------------------------------------
   // Acknowledge cycle encoding.
   // -----------------------------------------------------------------
   localparam logic [1:0] TT_ACK = 2'h3;
   localparam logic [1:0] TT_IDLE = 2'h0;
   localparam logic [26:0] ACK_ADDR_HI = 27'h07FFFFF;
   localparam logic [1:0] ACK_ADDR_LO = 2'h0;
   localparam logic [7:0] AUTOVECTOR_SELECT_BASE = 8'h18;

   // Request handling states, Gray coded along idle, ack, done, handler.
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_ACK = 2'h1,
      ST_DONE = 2'h3,
      ST_HNDL = 2'h2
   } eia_state_e;

endpackage

// ===== core/eia_sync_filter.sv
// Two-stage synchroniser followed by a two-sample stability filter.
// Assumes the raw input is asynchronous to mclk_in.
`timescale 1ns/10ps
module eia_sync_filter #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '1
) (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic [W-1:0] raw_in,
   output logic [W-1:0] filt_out
);

   logic [W-1:0] s1_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] filt_ff;
   logic [W-1:0] nxt_filt;

   // The output follows only a value seen on two consecutive samples.
   always_comb begin
      nxt_filt = filt_ff;
      if (s2_ff == s3_ff) begin
         nxt_filt = s3_ff;
      end
   end

   // Synchroniser chain and filtered output registers.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         s1_ff <= RST_VAL;
         s2_ff <= RST_VAL;
         s3_ff <= RST_VAL;
         filt_ff <= RST_VAL;
      end else begin
         s1_ff <= raw_in;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         filt_ff <= nxt_filt;
      end
   end

   assign filt_out = filt_ff;

   // A new output value was stable over two samples beforehand.
   AST_FILTER_STABLE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (filt_ff != $past(filt_ff)) |-> ($past(s2_ff) == $past(s3_ff)))
      else $error("Filtered output changed without two stable samples.");

endmodule

// ===== core/eia_top.sv
// What this block does
// - Source mask bits block levels one to six before they reach the core.
// - Core accepts only levels strictly above its three-bit priority mask, or a pending level seven edge.
// - Request lines are synchronised and must hold two samples to count.
// - All levels are level sensitive; level seven also reacts to rising edges.
// - Take on an instruction boundary; one handler instruction before the next.
// - Internal autovectored source gets its vector internally, no bus cycle.
// - External autovector skips the visible cycle unless the block bit is zero.
// - Level seven is nonmaskable; a steady level seven gives one interrupt.
// - Level seven dropping and returning after acknowledge gives a new interrupt.
// - Lowered mask with steady level seven retakes it; mask then returns to seven.
// - Acknowledge is a read with transfer type three and modifier equal to level.
// - Acknowledge address is high field, level in bits four to two, zeros below.
//
// Interrupt recognition and acknowledge sequencer with a small register file.
// Assumes request, data and acknowledge pins are asynchronous; core strobes are not.
`timescale 1ns/10ps
module eia_top (
   input wire logic mclk_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [31:0] reg_rdata_out,
   output logic irq_out,
   input wire logic [6:0] interrupt_request_lines_n_in,
   input wire logic int_req_in,
   input wire logic [2:0] int_level_in,
   input wire logic int_autovector_select_in,
   input wire logic [7:0] int_vector_in,
   input wire logic insn_boundary_in,
   output logic take_out,
   output logic [7:0] take_vector_out,
   output logic [2:0] take_level_out,
   output logic [2:0] core_mask_out,
   output logic [31:0] addr_out,
   output logic [1:0] transfer_type_field_out,
   output logic [2:0] transfer_modifier_field_out,
   output logic rw_out,
   output logic address_valid_strobe_n_out,
   input wire logic [31:0] data_in,
   input wire logic transfer_acknowledge_n_in
);

   // -----------------------------------------------------------------
   // Pin synchronisation.
   // -----------------------------------------------------------------
   logic [6:0] lines_n_filt;
   logic ta_n_filt;
   logic [7:0] vec_pin_sync;

   eia_sync_filter #(.W(7), .RST_VAL(7'h7F)) u_lines (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .raw_in(interrupt_request_lines_n_in),
      .filt_out(lines_n_filt)
   );

   eia_sync_filter #(.W(1), .RST_VAL(1'b1)) u_ta (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .raw_in(transfer_acknowledge_n_in),
      .filt_out(ta_n_filt)
   );

   eia_sync_filter #(.W(8), .RST_VAL(8'h00)) u_vec (
      .mclk_in(mclk_in),
      .sys_rst_in(sys_rst_in),
      .raw_in(data_in[31:24]),
      .filt_out(vec_pin_sync)
   );

   // -----------------------------------------------------------------
   // State declarations.
   // -----------------------------------------------------------------
   eia_pkg::eia_state_e state_ff, nxt_state;
   logic [2:0] core_mask_ff, nxt_core_mask;
   logic [6:0] srcmask_ff, nxt_srcmask;
   logic [6:0] avr_autovector_select_ff, nxt_avr_autovector_select;
   logic avr_blk_ff, nxt_avr_blk;
   logic [2:0] lvl_ff, nxt_lvl;
   logic [7:0] vector_ff, nxt_vector;
   logic use_autovector_select_ff, nxt_use_autovector_select;
   logic bus_cyc_ff, nxt_bus_cyc;
   logic nmi_pend_ff, nxt_nmi_pend;
   logic [2:0] raw_lvl_ff;
   logic [eia_pkg::EV_W-1:0] status_ff, nxt_status;
   logic [eia_pkg::EV_W-1:0] imask_ff, nxt_imask;
   logic [31:0] rdata_ff, nxt_rdata;
   logic [eia_pkg::EV_W-1:0] ev;
   logic [6:0] lines_act;
   logic [6:0] lines_eff;
   logic [2:0] raw_lvl;
   logic [2:0] ext_lvl;
   logic nmi_edge;
   logic ext_ok;
   logic int_ok;
   logic sel_int;
   logic [2:0] cand_lvl;
   logic cand_ok;
   logic wr_ctrl;

   // Highest active level among seven lines, zero when none.
   function automatic logic [2:0] top_level(input logic [6:0] act);
      logic [2:0] l;
      l = eia_pkg::LVL_NONE;
      for (int i = 0; i < eia_pkg::NUM_LVL; i++) begin
         if (act[i]) begin
            l = 3'(i + 1);
         end
      end
      return l;
   endfunction

   // -----------------------------------------------------------------
   // Request qualification.
   // -----------------------------------------------------------------
   // Level seven ignores its source mask bit; the others pass only if unmasked.
   always_comb begin
      lines_act = ~lines_n_filt;
      lines_eff = lines_act & ~{1'b0, srcmask_ff[5:0]};
      raw_lvl = top_level(lines_act);
      ext_lvl = top_level(lines_eff);
      nmi_edge = (raw_lvl == eia_pkg::NMI_LVL) && (raw_lvl_ff != eia_pkg::NMI_LVL);
      ext_ok = (ext_lvl > core_mask_ff) || nmi_pend_ff;
      int_ok = int_req_in && (int_level_in > core_mask_ff);
      sel_int = int_ok && (!ext_ok || (int_level_in > ext_lvl));
      cand_ok = ext_ok || int_ok;
      if (sel_int) begin
         cand_lvl = int_level_in;
      end else if (nmi_pend_ff) begin
         cand_lvl = eia_pkg::NMI_LVL;
      end else begin
         cand_lvl = ext_lvl;
      end
   end

   // -----------------------------------------------------------------
   // Acknowledge sequencer and core mask.
   // -----------------------------------------------------------------
   // Idle waits for an instruction boundary; done hands the vector to the core.
   always_comb begin
      nxt_state = state_ff;
      nxt_lvl = lvl_ff;
      nxt_vector = vector_ff;
      nxt_use_autovector_select = use_autovector_select_ff;
      nxt_bus_cyc = bus_cyc_ff;
      nxt_nmi_pend = nmi_pend_ff;
      nxt_core_mask = core_mask_ff;
      ev = '0;
      wr_ctrl = reg_wr_in && (reg_addr_in == eia_pkg::REG_CTRL);
      if (wr_ctrl) begin
         nxt_core_mask = reg_wdata_in[2:0];
      end
      case (state_ff)
         eia_pkg::ST_IDLE: begin
            if (insn_boundary_in && cand_ok) begin
               nxt_lvl = cand_lvl;
               if (sel_int) begin
                  nxt_bus_cyc = 1'b0;
                  nxt_vector = int_autovector_select_in ? (eia_pkg::AUTOVECTOR_SELECT_BASE + 8'(int_level_in)) :
                     int_vector_in;
                  nxt_state = eia_pkg::ST_DONE;
               end else begin
                  nxt_use_autovector_select = avr_autovector_select_ff[cand_lvl - 3'h1];
                  nxt_vector = eia_pkg::AUTOVECTOR_SELECT_BASE + 8'(cand_lvl);
                  if (avr_autovector_select_ff[cand_lvl - 3'h1] && avr_blk_ff) begin
                     nxt_bus_cyc = 1'b0;
                     nxt_state = eia_pkg::ST_DONE;
                  end else begin
                     nxt_bus_cyc = 1'b1;
                     nxt_state = eia_pkg::ST_ACK;
                  end
                  if (cand_lvl == eia_pkg::NMI_LVL) begin
                     nxt_nmi_pend = 1'b0;
                  end
               end
            end
         end
         eia_pkg::ST_ACK: begin
            if (!ta_n_filt) begin
               if (!use_autovector_select_ff) begin
                  nxt_vector = vec_pin_sync;
               end
               nxt_state = eia_pkg::ST_DONE;
            end
         end
         eia_pkg::ST_DONE: begin
            nxt_core_mask = lvl_ff;
            ev[eia_pkg::EV_ACK] = bus_cyc_ff;
            ev[eia_pkg::EV_AUTOVECTOR_SELECT] = !bus_cyc_ff;
            nxt_state = eia_pkg::ST_HNDL;
         end
         eia_pkg::ST_HNDL: begin
            if (insn_boundary_in) begin
               nxt_state = eia_pkg::ST_IDLE;
            end
         end
         default: begin
            nxt_state = eia_pkg::ST_IDLE;
         end
      endcase
      // A fresh edge wins over the clear at acknowledge start.
      if (nmi_edge) begin
         nxt_nmi_pend = 1'b1;
         ev[eia_pkg::EV_NMI] = 1'b1;
      end
   end

   // Sequencer registers.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         state_ff <= eia_pkg::ST_IDLE;
         lvl_ff <= eia_pkg::LVL_NONE;
         vector_ff <= '0;
         use_autovector_select_ff <= 1'b0;
         bus_cyc_ff <= 1'b0;
         nmi_pend_ff <= 1'b0;
         raw_lvl_ff <= eia_pkg::LVL_NONE;
         core_mask_ff <= eia_pkg::CORE_MASK_RST;
      end else begin
         state_ff <= nxt_state;
         lvl_ff <= nxt_lvl;
         vector_ff <= nxt_vector;
         use_autovector_select_ff <= nxt_use_autovector_select;
         bus_cyc_ff <= nxt_bus_cyc;
         nmi_pend_ff <= nxt_nmi_pend;
         raw_lvl_ff <= raw_lvl;
         core_mask_ff <= nxt_core_mask;
      end
   end

   // Acknowledge bus drive, idle values outside the cycle.
   always_comb begin
      if (state_ff == eia_pkg::ST_ACK) begin
         addr_out = {eia_pkg::ACK_ADDR_HI, lvl_ff, eia_pkg::ACK_ADDR_LO};
         transfer_type_field_out = eia_pkg::TT_ACK;
         transfer_modifier_field_out = lvl_ff;
         address_valid_strobe_n_out = 1'b0;
      end else begin
         addr_out = '0;
         transfer_type_field_out = eia_pkg::TT_IDLE;
         transfer_modifier_field_out = eia_pkg::LVL_NONE;
         address_valid_strobe_n_out = 1'b1;
      end
   end

   assign rw_out = 1'b1;
   assign take_out = (state_ff == eia_pkg::ST_DONE);
   assign take_vector_out = vector_ff;
   assign take_level_out = lvl_ff;
   assign core_mask_out = core_mask_ff;

   // -----------------------------------------------------------------
   // Register file and event interrupt.
   // -----------------------------------------------------------------
   // Writes update configuration; status clears by ones with set winning.
   always_comb begin
      nxt_srcmask = srcmask_ff;
      nxt_avr_autovector_select = avr_autovector_select_ff;
      nxt_avr_blk = avr_blk_ff;
      nxt_imask = imask_ff;
      nxt_status = status_ff;
      nxt_rdata = '0;
      if (reg_wr_in) begin
         case (reg_addr_in)
            eia_pkg::REG_SRCMASK: nxt_srcmask = reg_wdata_in[7:1];
            eia_pkg::REG_AVR: begin
               nxt_avr_autovector_select = reg_wdata_in[7:1];
               nxt_avr_blk = reg_wdata_in[eia_pkg::AVR_BLK_BIT];
            end
            eia_pkg::REG_STATUS: nxt_status = status_ff & ~reg_wdata_in[eia_pkg::EV_W-1:0];
            eia_pkg::REG_IMASK: nxt_imask = reg_wdata_in[eia_pkg::EV_W-1:0];
            default: nxt_imask = imask_ff;
         endcase
      end
      nxt_status = nxt_status | ev;
      if (reg_rd_in) begin
         case (reg_addr_in)
            eia_pkg::REG_CTRL: nxt_rdata = {29'h0, core_mask_ff};
            eia_pkg::REG_SRCMASK: nxt_rdata = {24'h0, srcmask_ff, 1'b0};
            eia_pkg::REG_AVR: nxt_rdata = {24'h0, avr_autovector_select_ff, avr_blk_ff};
            eia_pkg::REG_VECTOR: nxt_rdata = {21'h0, lvl_ff, vector_ff};
            eia_pkg::REG_STATUS: nxt_rdata = {29'h0, status_ff};
            eia_pkg::REG_IMASK: nxt_rdata = {29'h0, imask_ff};
            eia_pkg::REG_STATE: nxt_rdata = {25'h0, nmi_pend_ff, state_ff, 1'b0, lines_act[2:0]};
            default: nxt_rdata = '0;
         endcase
      end
   end

   // Register file storage.
   always_ff @(posedge mclk_in) begin
      if (sys_rst_in) begin
         srcmask_ff <= eia_pkg::SRCMASK_RST;
         avr_autovector_select_ff <= eia_pkg::AVR_AUTOVECTOR_SELECT_RST;
         avr_blk_ff <= eia_pkg::AVR_BLK_RST;
         imask_ff <= '0;
         status_ff <= '0;
         rdata_ff <= '0;
      end else begin
         srcmask_ff <= nxt_srcmask;
         avr_autovector_select_ff <= nxt_avr_autovector_select;
         avr_blk_ff <= nxt_avr_blk;
         imask_ff <= nxt_imask;
         status_ff <= nxt_status;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_out = rdata_ff;
   assign irq_out = |(status_ff & imask_ff);

   // -----------------------------------------------------------------
   // Checks.
   // -----------------------------------------------------------------
   sequence s_ack_start;
      (state_ff == eia_pkg::ST_IDLE) ##1 (state_ff == eia_pkg::ST_ACK);
   endsequence

   sequence s_leave_idle;
      (state_ff == eia_pkg::ST_IDLE) && (nxt_state != eia_pkg::ST_IDLE);
   endsequence

   AST_ACK_ADDR: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (state_ff == eia_pkg::ST_ACK) |->
      (addr_out[31:5] == eia_pkg::ACK_ADDR_HI && addr_out[4:2] == lvl_ff && addr_out[1:0] == 2'h0))
      else $error("Acknowledge address is wrong.");

   AST_ACK_TYPE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      s_ack_start |-> (transfer_type_field_out == eia_pkg::TT_ACK && rw_out &&
      transfer_modifier_field_out == addr_out[4:2] && !address_valid_strobe_n_out))
      else $error("Acknowledge cycle type or modifier is wrong.");

   AST_NO_STROBE_AUTOVECTOR_SELECT: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      ((state_ff == eia_pkg::ST_IDLE) ##1 (state_ff == eia_pkg::ST_DONE)) |->
      (address_valid_strobe_n_out && $past(address_valid_strobe_n_out)))
      else $error("Strobe asserted on an autovectored take.");

   AST_TAKE_BOUNDARY: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      s_leave_idle |-> insn_boundary_in)
      else $error("Interrupt taken off an instruction boundary.");

   AST_HANDLER_GAP: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      take_out |=> (!take_out && state_ff == eia_pkg::ST_HNDL) ##1 !take_out)
      else $error("Second take without a handler instruction.");

   AST_PRIORITY: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      s_leave_idle |-> (cand_lvl > core_mask_ff || (nmi_pend_ff && !sel_int)))
      else $error("Level not above core mask was taken.");

   AST_SRC_MASK: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (s_leave_idle and (!sel_int && !nmi_pend_ff)) |->
      (lines_act[cand_lvl - 3'h1] &&
      (cand_lvl == eia_pkg::NMI_LVL || !srcmask_ff[cand_lvl - 3'h1])))
      else $error("Masked source was taken.");

   AST_NMI_ONCE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (s_leave_idle and
      (!sel_int && cand_lvl == eia_pkg::NMI_LVL && raw_lvl == eia_pkg::NMI_LVL))
      |=> !nmi_pend_ff [*2])
      else $error("Steady level seven left a second edge pending.");

   AST_MASK_RAISE: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      take_out |=> (core_mask_ff == $past(take_level_out)))
      else $error("Core mask not raised to the taken level.");

   AST_EDGE_LATCH: assert property (@(posedge mclk_in) disable iff (sys_rst_in)
      (raw_lvl == eia_pkg::NMI_LVL && raw_lvl_ff != eia_pkg::NMI_LVL) |=> nmi_pend_ff)
      else $error("Level seven edge was not latched.");

endmodule

// ===== bench/eia_periph_model.sv
// Peripheral model: raises one request line and answers acknowledge reads.
// Assumes the bench picks the level and the answer delay between cycles.
`timescale 1ns/10ps
module eia_periph_model (
   input wire logic mclk_in,
   input wire logic [2:0] level_in,
   input wire logic [3:0] delay_in,
   input wire logic address_valid_strobe_n_in,
   input wire logic [2:0] transfer_modifier_field_in,
   output logic [6:0] interrupt_request_lines_n_out,
   output logic [31:0] data_out,
   output logic transfer_acknowledge_n_out
);
   // ---------------------------------------------
   // Request and answer
   // ---------------------------------------------
   logic [3:0] wait_ff;

   // One active-low line for the chosen level, held until the bench drops it.
   always_comb begin
      interrupt_request_lines_n_out = 7'h7F;
      if (level_in != 3'h0) begin
         interrupt_request_lines_n_out[level_in - 3'h1] = 1'b0;
      end
   end

   // Start from an idle bus.
   initial begin
      wait_ff = 4'h0;
      data_out = 32'h0;
      transfer_acknowledge_n_out = 1'b1;
   end

   // Waits the delay, then holds vector and acknowledge until the strobe ends.
   always @(posedge mclk_in) begin
      if (address_valid_strobe_n_in == 1'b0) begin
         wait_ff <= wait_ff + 4'h1;
         if (wait_ff >= delay_in) begin
            data_out <= {8'h40 + {5'h0, transfer_modifier_field_in}, 24'h0};
            transfer_acknowledge_n_out <= 1'b0;
         end
      end else begin
         wait_ff <= 4'h0;
         data_out <= ~data_out; // Released bus inverts the last vector every cycle.
         transfer_acknowledge_n_out <= 1'b1;
      end
   end
endmodule

// ===== bench/eia_top_tb.sv
// Self-checking bench for the interrupt recognition and acknowledge block.
// Assumes the peripheral model answers every acknowledge read.
`timescale 1ns/10ps
module eia_top_tb;
   logic mclk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] reg_addr_in = 8'h00;
   logic [31:0] reg_wdata_in = 32'h0;
   logic reg_wr_in = 1'b0;
   logic reg_rd_in = 1'b0;
   logic int_req_in = 1'b0;
   logic [2:0] int_level_in = 3'h0;
   logic int_autovector_select_in = 1'b0;
   logic [7:0] int_vector_in = 8'h00;
   logic insn_boundary_in = 1'b0;
   logic [2:0] per_lvl = 3'h0;
   logic [3:0] per_dly = 4'h0;
   logic [31:0] reg_rdata_out, addr_out, data_in;
   logic irq_out, take_out, rw_out, address_valid_strobe_n_out, transfer_acknowledge_n_in;
   logic [7:0] take_vector_out, v;
   logic [2:0] take_level_out, core_mask_out, transfer_modifier_field_out;
   logic [1:0] transfer_type_field_out;
   logic [6:0] interrupt_request_lines_n_in;
   int errors = 0;
   int cmp_count = 0;
   int cyc = 0;

   // ---------------------------------------------
   // Clock, design and peripheral
   // ---------------------------------------------
   // Free-running 100 MHz clock.
   always #5 mclk_in = ~mclk_in;

   eia_top u_eia_top (
      .mclk_in, .sys_rst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
      .reg_rdata_out, .irq_out, .interrupt_request_lines_n_in, .int_req_in,
      .int_level_in, .int_autovector_select_in, .int_vector_in, .insn_boundary_in, .take_out,
      .take_vector_out, .take_level_out, .core_mask_out, .addr_out,
      .transfer_type_field_out, .transfer_modifier_field_out, .rw_out,
      .address_valid_strobe_n_out, .data_in, .transfer_acknowledge_n_in
   );

   eia_periph_model u_eia_periph_model (
      .mclk_in, .level_in(per_lvl), .delay_in(per_dly),
      .address_valid_strobe_n_in(address_valid_strobe_n_out),
      .transfer_modifier_field_in(transfer_modifier_field_out),
      .interrupt_request_lines_n_out(interrupt_request_lines_n_in),
      .data_out(data_in), .transfer_acknowledge_n_out(transfer_acknowledge_n_in)
   );

   // ---------------------------------------------
   // Tasks
   // ---------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_wdata_in <= d;
      reg_wr_in <= 1'b1;
      @(posedge mclk_in);
      reg_wr_in <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge mclk_in);
      reg_addr_in <= a;
      reg_rd_in <= 1'b1;
      @(posedge mclk_in);
      reg_rd_in <= 1'b0;
      @(negedge mclk_in);
      chk("rdata", exp, reg_rdata_out);
   endtask

   // Raises the boundary until a take or a time limit; checks any acknowledge cycle.
   task automatic take_one(input logic exp, input logic bus, input logic [2:0] lvl,
                           input logic [7:0] vec);
      int n;
      logic saw_as;
      logic got;
      n = 0;
      saw_as = 1'b0;
      got = 1'b0;
      @(posedge mclk_in);
      insn_boundary_in <= 1'b1;
      while (got !== 1'b1 && n < 60) begin
         @(negedge mclk_in);
         n++;
         got = take_out;
         if (address_valid_strobe_n_out === 1'b0 && saw_as === 1'b0) begin
            saw_as = 1'b1;
            chk("ack_addr", {27'h7FFFFF, lvl, 2'h0}, addr_out);
            chk("ack_type", {26'h0, lvl, 1'b1, 2'h3}, {26'h0, transfer_modifier_field_out,
                rw_out, transfer_type_field_out});
         end
      end
      @(posedge mclk_in);
      insn_boundary_in <= 1'b0;
      chk("take", {31'h0, exp}, {31'h0, got});
      chk("bus_cycle", {31'h0, bus}, {31'h0, saw_as});
      if (exp) begin
         chk("vector", {24'h0, vec}, {24'h0, take_vector_out});
         chk("level", {29'h0, lvl}, {29'h0, take_level_out});
         @(negedge mclk_in);
         chk("core_mask", {29'h0, lvl}, {29'h0, core_mask_out});
         @(posedge mclk_in);
      end
   endtask

   // One external request served from a zero core mask.
   task automatic serve(input logic [2:0] lvl, input logic bus, input logic [7:0] vec);
      wr(eia_pkg::REG_CTRL, 32'h0);
      per_dly <= 4'($urandom_range(9));
      per_lvl <= lvl;
      take_one(1'b1, bus, lvl, vec);
      @(posedge mclk_in);
      per_lvl <= 3'h0;
      repeat (6) @(posedge mclk_in);
   endtask

   task automatic close_out;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Cuts a hang short.
   always @(posedge mclk_in) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   // Main sequence.
   initial begin
      void'($urandom(92248));
      repeat (20) @(posedge mclk_in);
      sys_rst_in <= 1'b0;
      @(negedge mclk_in);
      chk("mask_rst", 32'h7, {29'h0, core_mask_out});
      rd(eia_pkg::REG_AVR, 32'h1);
      rd(8'h3C, 32'h0);
      for (int i = 1; i < 7; i++) begin
         serve(3'(i), 1'b1, 8'h40 + 8'(i));
      end
      v = 8'($urandom_range(6, 1));
      wr(eia_pkg::REG_CTRL, {29'h0, v[2:0]});
      per_lvl <= v[2:0];
      take_one(1'b0, 1'b0, v[2:0], 8'h00);
      wr(eia_pkg::REG_SRCMASK, 32'h1 << v);
      wr(eia_pkg::REG_CTRL, 32'h0);
      take_one(1'b0, 1'b0, v[2:0], 8'h00);
      wr(eia_pkg::REG_SRCMASK, 32'h0);
      serve(v[2:0], 1'b1, 8'h40 + v);
      rd(eia_pkg::REG_STATUS, 32'h1);
      wr(eia_pkg::REG_IMASK, 32'h1);
      @(negedge mclk_in);
      chk("irq_on", 32'h1, {31'h0, irq_out});
      wr(eia_pkg::REG_IMASK, 32'h0);
      @(negedge mclk_in);
      chk("irq_masked", 32'h0, {31'h0, irq_out});
      wr(eia_pkg::REG_IMASK, 32'h1);
      wr(eia_pkg::REG_STATUS, 32'h1);
      @(negedge mclk_in);
      chk("irq_cleared", 32'h0, {31'h0, irq_out});
      rd(eia_pkg::REG_STATUS, 32'h0);
      wr(eia_pkg::REG_CTRL, 32'h0);
      per_lvl <= 3'h3;
      @(posedge mclk_in);
      per_lvl <= 3'h0;
      take_one(1'b0, 1'b0, 3'h3, 8'h00);
      wr(eia_pkg::REG_AVR, (32'h1 << v) | 32'h1);
      serve(v[2:0], 1'b0, 8'h18 + v);
      wr(eia_pkg::REG_AVR, 32'h1 << v);
      serve(v[2:0], 1'b1, 8'h18 + v);
      wr(eia_pkg::REG_AVR, 32'h1);
      wr(eia_pkg::REG_CTRL, 32'h0);
      int_level_in <= 3'h5;
      int_autovector_select_in <= 1'b1;
      int_vector_in <= 8'($urandom);
      int_req_in <= 1'b1;
      take_one(1'b1, 1'b0, 3'h5, 8'h1D);
      int_req_in <= 1'b0;
      wr(eia_pkg::REG_CTRL, 32'h0);
      v = 8'($urandom);
      int_autovector_select_in <= 1'b0;
      int_vector_in <= v;
      int_req_in <= 1'b1;
      take_one(1'b1, 1'b0, 3'h5, v);
      int_req_in <= 1'b0;
      wr(eia_pkg::REG_CTRL, 32'h7);
      per_lvl <= 3'h7;
      take_one(1'b1, 1'b1, 3'h7, 8'h47);
      take_one(1'b0, 1'b0, 3'h7, 8'h00);
      wr(eia_pkg::REG_CTRL, 32'h6);
      take_one(1'b1, 1'b1, 3'h7, 8'h47);
      per_lvl <= 3'h0;
      wr(eia_pkg::REG_SRCMASK, 32'hFE);
      repeat (6) @(posedge mclk_in);
      per_lvl <= 3'h7;
      take_one(1'b1, 1'b1, 3'h7, 8'h47);
      per_lvl <= 3'h0;
      rd(eia_pkg::REG_STATUS, 32'h7);
      close_out();
   end
endmodule
